// *** hw/sasc_map.vh ***
/*
 register offsets, field positions, scan modes and reset values
 for the converter scan control block; included by the design file.
*/
`ifndef SASC_MAP_VH
`define SASC_MAP_VH
// register word addresses (8-bit address bus)
`define SASC_ADDR_PATTERN_BASE 8'h00
`define SASC_ADDR_PATTERN_LAST 8'h0F
`define SASC_ADDR_SCAN_CTRL    8'h10
`define SASC_ADDR_SCAN_LEN     8'h11
`define SASC_ADDR_SCAN_STATUS  8'h12
`define SASC_ADDR_LP_CTRL      8'h13
`define SASC_ADDR_LP_RESULT1   8'h14
`define SASC_ADDR_LP_RESULT2   8'h15
`define SASC_ADDR_LP_STATUS    8'h16
// scan control fields
`define SASC_CTRL_START_BIT    0
`define SASC_CTRL_MODE_LSB     1
`define SASC_CTRL_SEL2_BIT     3
`define SASC_CTRL_ROUTE_BIT    4
`define SASC_CTRL_WSTRIG_BIT   5
`define SASC_CTRL_STOP_BIT     6
// scan modes
`define SASC_MODE_SINGLE       2'h0
`define SASC_MODE_DOUBLE       2'h1
`define SASC_MODE_ALTERNATE    2'h2
// pattern entry fields
`define SASC_PAT_CH_MSB        7
`define SASC_PAT_CH_LSB        4
`define SASC_PAT_RES_MSB       3
`define SASC_PAT_RES_LSB       2
`define SASC_PAT_ATT_MSB       1
`define SASC_PAT_ATT_LSB       0
// low-power control fields
`define SASC_LP_START1_BIT     0
`define SASC_LP_START2_BIT     1
// reset values
`define SASC_PATTERN_RESET     8'h00
`define SASC_LEN_RESET         4'hF
`endif

// *** hw/sasc_scan_control.v ***
/*
 converter scan control: two low-power single-shot controllers and a
 pattern-driven fast scan controller with 16-bit result words.
 assumes the analog converters answer a start pulse with a done pulse
 and result, and that serial-audio word select comes from a pin.
*/
// Function
// R01 - low-power start begins one conversion
// R02 - low-power result readable in result register
// R03 - low-power side never scans on its own
// R04 - coprocessor issues starts in deep sleep
// R05 - sixteen entries of channel, resolution, scaling
// R06 - entries applied in order, wrap after length
// R07 - entry is 4-bit channel, 2+2 codes
// R08 - single mode uses only one converter
// R09 - double mode drives both converters together
// R10 - alternate mode switches converters in turn
// R11 - single word: channel tag over 12 bits
// R12 - dual word: converter bit, tag, 11 bits
// R13 - result limited to 12 or 11 bits
// R14 - scan started by software or serial audio
// R15 - interrupt raised when scan finishes
// R16 - word select triggers measurement when routed
// R17 - data line flags result ready
// R18 - serial path connected only while routing set
// R19 - no single-conversion start on fast side
// R20 - entry packed channel, resolution, scaling
// R21 - one word per conversion in entry order
`include "sasc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sasc_scan_control
#(
   parameter DEPTH = 16                    // pattern entries
)
(
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [7:0]  regAddr,
   input  wire [15:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdata_q,
   input  wire        coprocStart1,
   input  wire        coprocStart2,
   output reg         lpConvStart1_q,
   output reg         lpConvStart2_q,
   input  wire        lpConvDone1,
   input  wire        lpConvDone2,
   input  wire [11:0] lpConvData1,
   input  wire [11:0] lpConvData2,
   output reg         fastConvStart1_q,
   output reg         fastConvStart2_q,
   output reg  [3:0]  fastChannelPick_q,
   output reg  [1:0]  fastResolution_q,
   output reg  [1:0]  fastScaling_q,
   input  wire        fastConvDone1,
   input  wire        fastConvDone2,
   input  wire [11:0] fastConvData1,
   input  wire [11:0] fastConvData2,
   input  wire        serialWordSelect,
   output reg         serialDataReady_q,
   output reg  [15:0] dmaWord_q,
   output reg         dmaValid_q,
   output reg         scanDoneIrq_q
);

   // scan states, one-hot
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_ISSUE = 4'h2;
   localparam [3:0] ST_WAIT = 4'h4;
   localparam [3:0] ST_EMIT = 4'h8;

   reg  [7:0]  patternMem_q [0:DEPTH-1];   // pattern table storage
   reg  [3:0]  scanState_q;                // scan sequencer state
   reg  [3:0]  entryIdx_q;                 // current entry
   reg  [3:0]  scanLen_q;                  // last entry index
   reg  [1:0]  scanMode_q;                 // mode select
   reg         singleSel2_q;               // single mode converter pick
   reg         routeSerial_q;              // route results to serial audio
   reg         wsTrigEn_q;                 // word select trigger enable
   reg         continuous_q;               // wrap and repeat until stop
   reg         altTurn_q;                  // alternate converter turn
   reg         wait1_q;                    // awaiting converter one
   reg         wait2_q;                    // awaiting converter two
   reg  [11:0] res1_q;                     // captured result one
   reg  [11:0] res2_q;                     // captured result two
   reg         emit2_q;                    // second word pending
   reg         scanDoneSticky_q;           // finished flag
   reg  [11:0] lpResult1_q;                // low-power result one
   reg  [11:0] lpResult2_q;                // low-power result two
   reg         lpBusy1_q;                  // low-power busy one
   reg         lpBusy2_q;                  // low-power busy two
   reg         wsSync1_q;                  // word select sync stage one
   reg         wsSync2_q;                  // word select sync stage two
   reg         wsPrev_q;                   // word select edge memory
   wire        wsEdge;                     // word select rising edge
   wire        swStart;                    // software scan start
   wire        startScan;                  // any scan start
   wire [7:0]  curEntry;                   // current pattern entry
   integer     i;                          // reset loop index

   // pack a result word for the given mode
   function [15:0] packWord;
      input [1:0]  mode;
      input        conv2;
      input [3:0]  ch;
      input [11:0] data;
      begin
         if (mode == `SASC_MODE_SINGLE)
            packWord = {ch, data};                       // R11 R13
         else
            packWord = {conv2, ch, data[11:1]};          // R12 R13
      end
   endfunction

   assign wsEdge    = wsSync2_q & ~wsPrev_q;
   assign swStart   = regWr && (regAddr == `SASC_ADDR_SCAN_CTRL)
                      && regWdata[`SASC_CTRL_START_BIT];
   // word select only counts while routed to the serial path
   assign startScan = swStart || (wsEdge && wsTrigEn_q && routeSerial_q); // R14 R16
   assign curEntry  = patternMem_q[entryIdx_q];

   // word select synchroniser
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wsSync1_q <= 1'b0;
         wsSync2_q <= 1'b0;
         wsPrev_q  <= 1'b0;
      end
      else
      begin
         wsSync1_q <= serialWordSelect;
         wsSync2_q <= wsSync1_q;
         wsPrev_q  <= wsSync2_q;
      end
   end

   // register writes and configuration
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            patternMem_q[i] <= `SASC_PATTERN_RESET;
         scanLen_q     <= `SASC_LEN_RESET;
         scanMode_q    <= `SASC_MODE_SINGLE;
         singleSel2_q  <= 1'b0;
         routeSerial_q <= 1'b0;
         wsTrigEn_q    <= 1'b0;
      end
      else if (regWr)
      begin
         if (regAddr <= `SASC_ADDR_PATTERN_LAST)
            patternMem_q[regAddr[3:0]] <= regWdata[7:0];  // R05 R07 R20
         else if (regAddr == `SASC_ADDR_SCAN_CTRL)
         begin
            scanMode_q    <= regWdata[`SASC_CTRL_MODE_LSB+1:`SASC_CTRL_MODE_LSB];
            singleSel2_q  <= regWdata[`SASC_CTRL_SEL2_BIT];
            routeSerial_q <= regWdata[`SASC_CTRL_ROUTE_BIT]; // R18
            wsTrigEn_q    <= regWdata[`SASC_CTRL_WSTRIG_BIT];
         end
         else if (regAddr == `SASC_ADDR_SCAN_LEN)
            scanLen_q <= regWdata[3:0];
      end
   end

   // low-power single-shot controllers; no sequencing of their own
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lpConvStart1_q <= 1'b0;
         lpConvStart2_q <= 1'b0;
         lpBusy1_q      <= 1'b0;
         lpBusy2_q      <= 1'b0;
         lpResult1_q    <= 12'h000;
         lpResult2_q    <= 12'h000;
      end
      else
      begin
         // start pulse from software or coprocessor
         lpConvStart1_q <= ~lpBusy1_q & (coprocStart1 | (regWr &&          // R01 R04
            regAddr == `SASC_ADDR_LP_CTRL && regWdata[`SASC_LP_START1_BIT]));
         lpConvStart2_q <= ~lpBusy2_q & (coprocStart2 | (regWr &&          // R01 R04
            regAddr == `SASC_ADDR_LP_CTRL && regWdata[`SASC_LP_START2_BIT]));
         if (lpConvStart1_q)
            lpBusy1_q <= 1'b1;
         else if (lpConvDone1)
            lpBusy1_q <= 1'b0;                                            // R03
         if (lpConvStart2_q)
            lpBusy2_q <= 1'b1;
         else if (lpConvDone2)
            lpBusy2_q <= 1'b0;                                            // R03
         if (lpConvDone1)
            lpResult1_q <= lpConvData1;                                   // R02
         if (lpConvDone2)
            lpResult2_q <= lpConvData2;                                   // R02
      end
   end

   // fast scan sequencer; only whole scans can be started
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         scanState_q       <= ST_IDLE;
         entryIdx_q        <= 4'h0;
         continuous_q      <= 1'b0;
         altTurn_q         <= 1'b0;
         wait1_q           <= 1'b0;
         wait2_q           <= 1'b0;
         res1_q            <= 12'h000;
         res2_q            <= 12'h000;
         emit2_q           <= 1'b0;
         fastConvStart1_q  <= 1'b0;
         fastConvStart2_q  <= 1'b0;
         fastChannelPick_q <= 4'h0;
         fastResolution_q  <= 2'h0;
         fastScaling_q     <= 2'h0;
         dmaWord_q         <= 16'h0000;
         dmaValid_q        <= 1'b0;
         serialDataReady_q <= 1'b0;
         scanDoneIrq_q     <= 1'b0;
         scanDoneSticky_q  <= 1'b0;
      end
      else
      begin
         fastConvStart1_q  <= 1'b0;
         fastConvStart2_q  <= 1'b0;
         dmaValid_q        <= 1'b0;
         serialDataReady_q <= 1'b0;
         scanDoneIrq_q     <= 1'b0;
         // done flag: set wins over clear on status read
         if (regRd && regAddr == `SASC_ADDR_SCAN_STATUS)
            scanDoneSticky_q <= 1'b0;
         if (regWr && regAddr == `SASC_ADDR_SCAN_CTRL
             && regWdata[`SASC_CTRL_STOP_BIT])
            continuous_q <= 1'b0;
         case (scanState_q)
            ST_IDLE:
            begin
               if (startScan)                                             // R19
               begin
                  entryIdx_q   <= 4'h0;
                  altTurn_q    <= 1'b0;
                  continuous_q <= 1'b0;
                  scanState_q  <= ST_ISSUE;
               end
            end
            ST_ISSUE:
            begin
               // apply current entry to the converters
               fastChannelPick_q <= curEntry[`SASC_PAT_CH_MSB:`SASC_PAT_CH_LSB];
               fastResolution_q  <= curEntry[`SASC_PAT_RES_MSB:`SASC_PAT_RES_LSB];
               fastScaling_q     <= curEntry[`SASC_PAT_ATT_MSB:`SASC_PAT_ATT_LSB];
               if (scanMode_q == `SASC_MODE_DOUBLE)
               begin
                  fastConvStart1_q <= 1'b1;                               // R09
                  fastConvStart2_q <= 1'b1;
                  wait1_q <= 1'b1;
                  wait2_q <= 1'b1;
               end
               else if (scanMode_q == `SASC_MODE_ALTERNATE)
               begin
                  fastConvStart1_q <= ~altTurn_q;                         // R10
                  fastConvStart2_q <= altTurn_q;
                  wait1_q <= ~altTurn_q;
                  wait2_q <= altTurn_q;
               end
               else
               begin
                  fastConvStart1_q <= ~singleSel2_q;                      // R08
                  fastConvStart2_q <= singleSel2_q;
                  wait1_q <= ~singleSel2_q;
                  wait2_q <= singleSel2_q;
               end
               scanState_q <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (fastConvDone1)
               begin
                  res1_q  <= fastConvData1;
                  wait1_q <= 1'b0;
               end
               if (fastConvDone2)
               begin
                  res2_q  <= fastConvData2;
                  wait2_q <= 1'b0;
               end
               if ((wait1_q & ~fastConvDone1) == 1'b0 &&
                   (wait2_q & ~fastConvDone2) == 1'b0)
               begin
                  emit2_q     <= 1'b0;
                  scanState_q <= ST_EMIT;
               end
            end
            ST_EMIT:
            begin
               // one word per conversion, converter one first
               dmaValid_q        <= 1'b1;                                 // R21
               serialDataReady_q <= routeSerial_q;                        // R17 R18
               if (scanMode_q == `SASC_MODE_DOUBLE && !emit2_q)
               begin
                  dmaWord_q <= packWord(scanMode_q, 1'b0, fastChannelPick_q, res1_q);
                  emit2_q   <= 1'b1;
               end
               else
               begin
                  if (scanMode_q == `SASC_MODE_DOUBLE)
                     dmaWord_q <= packWord(scanMode_q, 1'b1, fastChannelPick_q, res2_q);
                  else if (scanMode_q == `SASC_MODE_ALTERNATE)
                     dmaWord_q <= packWord(scanMode_q, altTurn_q, fastChannelPick_q,
                                           altTurn_q ? res2_q : res1_q);
                  else
                     dmaWord_q <= packWord(scanMode_q, singleSel2_q, fastChannelPick_q,
                                           singleSel2_q ? res2_q : res1_q);
                  altTurn_q <= ~altTurn_q;
                  if (entryIdx_q == scanLen_q)
                  begin
                     entryIdx_q       <= 4'h0;                            // R06
                     scanDoneIrq_q    <= 1'b1;                            // R15
                     scanDoneSticky_q <= 1'b1;
                     scanState_q      <= continuous_q ? ST_ISSUE : ST_IDLE;
                  end
                  else
                  begin
                     entryIdx_q  <= entryIdx_q + 4'h1;                    // R06
                     scanState_q <= ST_ISSUE;
                  end
               end
            end
            default:
               scanState_q <= ST_IDLE;
         endcase
         // continuous repeat requested with the start
         if (scanState_q == ST_IDLE && swStart && regWdata[`SASC_CTRL_STOP_BIT] == 1'b0
             && regWdata[7])
            continuous_q <= 1'b1;
      end
   end

   // register read mux; data valid the cycle after the strobe
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         regRdata_q <= 16'h0000;
      else if (regRd)
      begin
         if (regAddr <= `SASC_ADDR_PATTERN_LAST)
            regRdata_q <= {8'h00, patternMem_q[regAddr[3:0]]};
         else if (regAddr == `SASC_ADDR_SCAN_CTRL)
            regRdata_q <= {10'h000, wsTrigEn_q, routeSerial_q, singleSel2_q,
                           scanMode_q, 1'b0};
         else if (regAddr == `SASC_ADDR_SCAN_LEN)
            regRdata_q <= {12'h000, scanLen_q};
         else if (regAddr == `SASC_ADDR_SCAN_STATUS)
            regRdata_q <= {7'h00, entryIdx_q, continuous_q, scanState_q[0] ? 1'b0 : 1'b1,
                           2'h0, scanDoneSticky_q | scanDoneIrq_q};
         else if (regAddr == `SASC_ADDR_LP_RESULT1)
            regRdata_q <= {4'h0, lpResult1_q};                            // R02
         else if (regAddr == `SASC_ADDR_LP_RESULT2)
            regRdata_q <= {4'h0, lpResult2_q};                            // R02
         else if (regAddr == `SASC_ADDR_LP_STATUS)
            regRdata_q <= {14'h0000, lpBusy2_q, lpBusy1_q};
         else
            regRdata_q <= 16'h0000;
      end
      else
         regRdata_q <= 16'h0000;
   end

endmodule // sasc_scan_control
`default_nettype wire

// *** verif/sasc_conv_model.sv ***
/*
 behavioural converter: done pulse and result LAT cycles after start;
 assumes start is a one-cycle pulse from the scan control block.
*/
`timescale 1ns/1ps
`default_nettype none
module sasc_conv_model
#(
   parameter LAT = 2                        // cycles from start to done
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [11:0] value,
   output wire logic        done,
   output wire logic [11:0] data
);
   logic [7:0]  cnt_q;                      // cycles left to done
   logic [11:0] val_q;                      // result captured at start
   // latch result on start, count down to done
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 8'h00;
         val_q <= 12'h000;
      end
      else if (start)
      begin
         cnt_q <= 8'(LAT);
         val_q <= value;
      end
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
   end
   assign done = (cnt_q == 8'h01);
   // released data lines show the inverse, never a stale match
   assign data = done ? val_q : ~val_q;
endmodule // sasc_conv_model
`default_nettype wire

// *** verif/sasc_scan_control_props.sv ***
/*
 port checker for the scan control block.
 assumes one clock domain and control writes in idle periods.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sasc_map.vh"
module sasc_scan_control_props
#(
   parameter DEPTH = 16
)
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWr,
   input wire logic        coprocStart1,
   input wire logic        lpConvStart1_q,
   input wire logic        fastConvStart1_q,
   input wire logic        fastConvStart2_q,
   input wire logic [3:0]  fastChannelPick_q,
   input wire logic        fastConvDone1,
   input wire logic        fastConvDone2,
   input wire logic        serialDataReady_q,
   input wire logic [15:0] dmaWord_q,
   input wire logic        dmaValid_q,
   input wire logic        scanDoneIrq_q
);
   logic [1:0] mode_q;                      // last written scan mode
   logic       route_q;                     // serial routing bit
   logic [3:0] chan_q;                      // channel of last issue
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // mirror control writes and issued channel
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_q <= 2'h0;
         route_q <= 1'h0;
         chan_q <= 4'h0;
      end
      else
      begin
         if (regWr && regAddr == `SASC_ADDR_SCAN_CTRL)
         begin
            mode_q <= regWdata[2:1];
            route_q <= regWdata[4];
         end
         if (fastConvStart1_q || fastConvStart2_q)
            chan_q <= fastChannelPick_q;
      end
   end
   chk_lp_start_cause: assert property (
      lpConvStart1_q |-> $past(coprocStart1 || (regWr && regWdata[0]
         && regAddr == `SASC_ADDR_LP_CTRL))) else $error("lp start without request");
   chk_single_one_conv: assert property (
      mode_q == `SASC_MODE_SINGLE |-> !(fastConvStart1_q && fastConvStart2_q))
      else $error("single mode drove both converters");
   chk_double_both_conv: assert property (
      mode_q == `SASC_MODE_DOUBLE |-> fastConvStart1_q == fastConvStart2_q)
      else $error("double mode start not paired");
   chk_alt_one_conv: assert property (
      mode_q == `SASC_MODE_ALTERNATE |-> !(fastConvStart1_q && fastConvStart2_q))
      else $error("alternate mode drove both converters");
   chk_word_chan_tag: assert property (
      dmaValid_q |-> ((mode_q == `SASC_MODE_SINGLE) ? dmaWord_q[15:12]
         : dmaWord_q[14:11]) == chan_q) else $error("word channel tag wrong");
   chk_word_after_done: assert property (
      (fastConvDone1 || fastConvDone2) |-> ##[1:8] dmaValid_q)
      else $error("no word after conversion");
   chk_serial_route: assert property (
      serialDataReady_q |-> dmaValid_q && route_q) else $error("stray serial ready");
   chk_irq_with_word: assert property (
      scanDoneIrq_q |-> dmaValid_q) else $error("scan done without word");
   cover property (scanDoneIrq_q && route_q);
   cover property (dmaValid_q && mode_q == `SASC_MODE_ALTERNATE);
   cover property (fastConvStart1_q && fastConvStart2_q);
endmodule // sasc_scan_control_props
bind sasc_scan_control sasc_scan_control_props #(.DEPTH(DEPTH)) i_props (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .coprocStart1(coprocStart1), .lpConvStart1_q(lpConvStart1_q),
   .fastConvStart1_q(fastConvStart1_q), .fastConvStart2_q(fastConvStart2_q),
   .fastChannelPick_q(fastChannelPick_q), .fastConvDone1(fastConvDone1),
   .fastConvDone2(fastConvDone2), .serialDataReady_q(serialDataReady_q),
   .dmaWord_q(dmaWord_q), .dmaValid_q(dmaValid_q), .scanDoneIrq_q(scanDoneIrq_q));
`default_nettype wire

// *** verif/sasc_scan_control_tb_top.sv ***
/*
 self-checking bench for the scan control block.
 assumes fast converter models answer with results derived from the channel.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sasc_map.vh"
module sasc_scan_control_tb_top;
   logic sys_clk, rst, regWr, regRd, coprocStart1, coprocStart2, serialWordSelect;
   logic [7:0] regAddr;
   logic [15:0] regWdata, regRdata_q, dmaWord_q;
   logic lpConvStart1_q, lpConvStart2_q, lpConvDone1, lpConvDone2;
   logic fastConvStart1_q, fastConvStart2_q, fastConvDone1, fastConvDone2;
   logic [11:0] lpConvData1, lpConvData2, fastConvData1, fastConvData2;
   logic [3:0] fastChannelPick_q;
   logic [1:0] fastResolution_q, fastScaling_q;
   logic serialDataReady_q, dmaValid_q, scanDoneIrq_q;
   logic [15:0] wordQ[$];                   // words seen on the dma port
   logic [7:0] fieldQ[$];                   // entry fields at each issue
   logic [11:0] lpVal1 = 12'h9C3, lpVal2 = 12'h5A6; // low-power converter inputs
   int serCnt, irqCnt, lpCnt, failCount, samplesChecked;
   sasc_scan_control i_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
      .coprocStart1(coprocStart1), .coprocStart2(coprocStart2),
      .lpConvStart1_q(lpConvStart1_q), .lpConvStart2_q(lpConvStart2_q),
      .lpConvDone1(lpConvDone1), .lpConvDone2(lpConvDone2), .lpConvData1(lpConvData1),
      .lpConvData2(lpConvData2), .fastConvStart1_q(fastConvStart1_q),
      .fastConvStart2_q(fastConvStart2_q), .fastChannelPick_q(fastChannelPick_q),
      .fastResolution_q(fastResolution_q), .fastScaling_q(fastScaling_q),
      .fastConvDone1(fastConvDone1), .fastConvDone2(fastConvDone2),
      .fastConvData1(fastConvData1), .fastConvData2(fastConvData2),
      .serialWordSelect(serialWordSelect), .serialDataReady_q(serialDataReady_q),
      .dmaWord_q(dmaWord_q), .dmaValid_q(dmaValid_q), .scanDoneIrq_q(scanDoneIrq_q));
   // slow low-power converters, prompt and slower fast converters
   sasc_conv_model #(.LAT(6)) i_lp1 (.sys_clk(sys_clk), .rst(rst), .start(lpConvStart1_q),
      .value(lpVal1), .done(lpConvDone1), .data(lpConvData1));
   sasc_conv_model #(.LAT(5)) i_lp2 (.sys_clk(sys_clk), .rst(rst), .start(lpConvStart2_q),
      .value(lpVal2), .done(lpConvDone2), .data(lpConvData2));
   sasc_conv_model #(.LAT(1)) i_f1 (.sys_clk(sys_clk), .rst(rst), .start(fastConvStart1_q),
      .value({fastChannelPick_q, 8'h5A}), .done(fastConvDone1), .data(fastConvData1));
   sasc_conv_model #(.LAT(3)) i_f2 (.sys_clk(sys_clk), .rst(rst), .start(fastConvStart2_q),
      .value({~fastChannelPick_q, 8'hC3}), .done(fastConvDone2), .data(fastConvData2));
   initial
   begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end
   // record words, issued fields and event counts
   always @(posedge sys_clk)
   begin
      if (dmaValid_q === 1'h1) wordQ.push_back(dmaWord_q);
      if (fastConvStart1_q || fastConvStart2_q)
         fieldQ.push_back({fastChannelPick_q, fastResolution_q, fastScaling_q});
      serCnt += int'(serialDataReady_q);
      irqCnt += int'(scanDoneIrq_q);
      lpCnt += int'(lpConvDone1) + int'(lpConvDone2);
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samplesChecked++;
      if (g !== e)
      begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge sys_clk);
      regWr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge sys_clk);
      regRd <= 1'h0;
      #1 d = regRdata_q;
   endtask
   // bounded wait on lp done count (0) or word count (1)
   task automatic waitFor(input int n, input int which);
      int i, v;
      for (i = 0; i < 800; i++)
      begin
         @(posedge sys_clk);
         #1 v = (which == 0) ? lpCnt : wordQ.size();
         if (v >= n) return;
      end
      failCount++;
      $display("CHECK FAILED wait expected %0d seen %0d", n, v);
      summarize();
   endtask
   task automatic testRegisters();
      int i;
      logic [15:0] v;
      rd(`SASC_ADDR_PATTERN_BASE, v);
      chk("pattern reset", 16'h0000, v);
      rd(`SASC_ADDR_SCAN_LEN, v);
      chk("length reset", 16'h000F, v);
      rd(8'h3F, v);
      chk("unmapped read", 16'h0000, v);
      for (i = 0; i < 16; i++)
         wr(`SASC_ADDR_PATTERN_BASE + i[7:0], {8'h00, i[3:0], i[1:0], ~i[1:0]});
      rd(`SASC_ADDR_PATTERN_LAST, v);
      chk("pattern entry", 16'h00FC, v);
   endtask
   task automatic testLowPower();
      logic [15:0] v;
      wr(`SASC_ADDR_LP_CTRL, 16'h0001);
      waitFor(1, 0);
      rd(`SASC_ADDR_LP_RESULT1, v);
      chk("lp result one", {4'h0, lpVal1}, v);
      @(posedge sys_clk);
      coprocStart2 <= 1'h1;
      @(posedge sys_clk);
      coprocStart2 <= 1'h0;
      waitFor(2, 0);
      rd(`SASC_ADDR_LP_RESULT2, v);
      chk("lp result two", {4'h0, lpVal2}, v);
      chk("lp dma words", 16'h0000, wordQ.size());
   endtask
   // one scan: ctrl bits, last entry index; judges words and fields
   task automatic runScan(input logic [15:0] ctrl, input int last);
      int n, k, e;
      logic [1:0] m;
      logic c;
      logic [11:0] d;
      m = ctrl[2:1];
      n = (last + 1) * ((m == `SASC_MODE_DOUBLE) ? 2 : 1) * (ctrl[7] ? 2 : 1);
      wordQ.delete();
      fieldQ.delete();
      serCnt = 0;
      irqCnt = 0;
      wr(`SASC_ADDR_SCAN_LEN, last[15:0]);
      wr(`SASC_ADDR_SCAN_CTRL, ctrl);
      if (ctrl[5])
      begin
         serialWordSelect <= 1'h1;
         repeat (4) @(posedge sys_clk);
         serialWordSelect <= 1'h0;
      end
      waitFor(n, 1);
      for (k = 0; k < n; k++)
      begin
         e = ((m == `SASC_MODE_DOUBLE) ? k / 2 : k) % (last + 1);
         c = (m == `SASC_MODE_SINGLE) ? ctrl[3] : k[0];
         d = c ? {~e[3:0], 8'hC3} : {e[3:0], 8'h5A};
         chk("dma word", (m == `SASC_MODE_SINGLE) ? {e[3:0], d} : {c, e[3:0], d[11:1]}, wordQ[k]);
         if (m == `SASC_MODE_ALTERNATE && k > 0)
            chk("converter turn", {15'h0000, ~wordQ[k - 1][15]}, {15'h0000, c});
      end
      for (k = 0; k <= last; k++)
         chk("entry fields", {8'h00, k[3:0], k[1:0], ~k[1:0]}, {8'h00, fieldQ[k]});
      chk("ready count", ctrl[4] ? n[15:0] : 16'h0000, serCnt[15:0]);
      chk("irq count", ctrl[7] ? 16'h0002 : 16'h0001, irqCnt[15:0]);
   endtask
   initial
   begin
      rst = 1'h1;
      {regWr, regRd} = 2'h0;
      regAddr = 8'h00;
      regWdata = 16'h0000;
      coprocStart1 = 1'h0;
      coprocStart2 = 1'h0;
      serialWordSelect = 1'h0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'h0;
      testRegisters();
      testLowPower();
      runScan(16'h0011, 15);
      runScan(16'h0009, 2);
      runScan(16'h0003, 3);
      runScan(16'h0015, 4);
      runScan(16'h0030, 1);
      runScan(16'h0081, 1);
      summarize();
   end
endmodule // sasc_scan_control_tb_top
`default_nettype wire
